// >>> hw/psfs_pkg.sv
// constants, states and carriers shared by the power switch supervisor
package psfs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int unsigned CLK_HZ     = 10_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned BLANK_MS   = 32;
    localparam int unsigned LONG_MS    = 128;
    localparam int unsigned BLANK_CYC  = BLANK_MS * CYC_PER_MS;
    localparam int unsigned LONG_CYC   = LONG_MS * CYC_PER_MS;
    localparam int          TMR_W      = 32;

    ////////////////////////////////////////////////////////////////////////
    // register map, byte addresses on apb
    localparam int          APB_AW      = 8;
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_STATUS = 8'h04;
    localparam logic [7:0]  ADDR_FLAGS  = 8'h08;
    localparam logic [7:0]  STEP_RST    = 8'h10;
    localparam int          STEP_LSB    = 0;
    localparam int          ST_STATE_LSB = 0;
    localparam int          ST_GATE_BIT  = 3;
    localparam int          ST_FAULT_BIT = 4;
    localparam int          ST_GRACE_BIT = 5;
    localparam int          ST_LSEL_BIT  = 6;
    localparam int          ST_DRIVE_LSB = 8;
    localparam logic [7:0]  DRIVE_FULL  = 8'hFF;

    ////////////////////////////////////////////////////////////////////////
    // switch states, gray along off-ramp-on-sag-hot
    typedef enum logic [2:0] {
        ST_OFF     = 3'b000,
        ST_RAMP    = 3'b001,
        ST_ON      = 3'b011,
        ST_SAG_OFF = 3'b010,
        ST_HOT_OFF = 3'b110
    } psfs_state_t;

    // comparator and pin indications, all asynchronous
    typedef struct packed {
        logic lockout;
        logic sag;
        logic limNorm;
        logic limSurge;
        logic overTemp;
        logic cooled;
        logic enable;
    } psfs_flags_t;

endpackage : psfs_pkg

// >>> hw/psfs_supervisor.sv
// supervisor of a current-limited high-side switch with apb status
`timescale 1ns/10ps
`default_nettype none
module psfs_supervisor
    import psfs_pkg::*;
#(
    parameter bit          EN_ACTIVE_HIGH = 1'b1,
    parameter bit          SURGE_GRACE    = 1'b0,
    parameter int unsigned SHORT_CYC      = BLANK_CYC,
    parameter int unsigned GRACE_CYC      = LONG_CYC
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire psfs_flags_t       flagsPin,
    output logic                   gateOn,
    output logic [7:0]             gateDrive,
    output logic                   limitSel,
    output logic                   faultO,
    output logic                   faultOe_n,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr
);

    // every check below samples on the core clock, off during reset
    default clocking chkClk @(posedge core_clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    // synchronised indications
    logic [$bits(psfs_flags_t)-1:0] flagsVec;
    psfs_flags_t                    flags;
    logic                           enabled;
    logic                           runOk;

    psfs_sync #(
        .W($bits(psfs_flags_t))
    ) u_sync (
        .core_clk(core_clk),
        .rst     (rst),
        .asyncIn (flagsPin),
        .syncOut (flagsVec)
    );

    assign flags   = psfs_flags_t'(flagsVec);
    assign enabled = (flags.enable == EN_ACTIVE_HIGH);
    // lockout makes the enable pin meaningless
    assign runOk   = enabled && !flags.lockout;

    ////////////////////////////////////////////////////////////////////////
    // interval timers
    localparam logic [TMR_W-1:0] SHORT_LIM = TMR_W'(SHORT_CYC);
    localparam logic [TMR_W-1:0] GRACE_LIM = TMR_W'(GRACE_CYC);

    psfs_state_t stateQ;
    psfs_state_t stateD;
    logic [7:0]  stepQ;
    logic        faultQ;
    logic        sagDone;
    logic        offDone;
    logic        graceDone;
    logic        asrtDone;
    logic        relDone;
    logic        graceActive;
    logic        faultCond;
    logic        limiting;
    logic        turnOn;

    assign gateOn = (stateQ == ST_RAMP) || (stateQ == ST_ON);
    assign turnOn = (stateD == ST_RAMP) && (stateQ != ST_RAMP);

    // sag only counts with the switch on
    psfs_timer #(.W(TMR_W)) u_sag (
        .core_clk(core_clk),
        .rst     (rst),
        .run     (gateOn && flags.sag),
        .clr     (!(gateOn && flags.sag)),
        .limit   (SHORT_LIM),
        .done    (sagDone)
    );

    psfs_timer #(.W(TMR_W)) u_off (
        .core_clk(core_clk),
        .rst     (rst),
        .run     (stateQ == ST_SAG_OFF),
        .clr     (stateQ != ST_SAG_OFF),
        .limit   (GRACE_LIM),
        .done    (offDone)
    );

    // grace restarts on every turn-on and runs to its end
    psfs_timer #(.W(TMR_W)) u_grace (
        .core_clk(core_clk),
        .rst     (rst),
        .run     (stateQ != ST_OFF),
        .clr     (turnOn || stateQ == ST_OFF),
        .limit   (GRACE_LIM),
        .done    (graceDone)
    );

    psfs_timer #(.W(TMR_W)) u_asrt (
        .core_clk(core_clk),
        .rst     (rst),
        .run     (faultCond && !faultQ),
        .clr     (!faultCond || faultQ),
        .limit   (SHORT_LIM),
        .done    (asrtDone)
    );

    // release hold, restarted whenever the fault returns
    psfs_timer #(.W(TMR_W)) u_rel (
        .core_clk(core_clk),
        .rst     (rst),
        .run     (faultQ && !faultCond),
        .clr     (faultCond || !faultQ),
        .limit   (SURGE_GRACE ? GRACE_LIM : SHORT_LIM),
        .done    (relDone)
    );

    ////////////////////////////////////////////////////////////////////////
    // current limit selection and fault condition
    assign graceActive = SURGE_GRACE && gateOn && !graceDone;
    assign limitSel    = graceActive;
    assign limiting    = gateOn &&
                         (limitSel ? flags.limSurge : flags.limNorm);
    assign faultCond   = limiting || (stateQ == ST_HOT_OFF);

    ////////////////////////////////////////////////////////////////////////
    // switch state machine
    always_comb begin
        stateD = stateQ;
        unique case (stateQ)
            ST_OFF: begin
                if (runOk) begin
                    stateD = ST_RAMP;
                end
            end
            ST_RAMP, ST_ON: begin
                if (!runOk) begin
                    stateD = ST_OFF;
                end else if (flags.overTemp) begin
                    stateD = ST_HOT_OFF;
                end else if (sagDone) begin
                    // sag wins even inside grace
                    stateD = ST_SAG_OFF;
                end else if (stateQ == ST_RAMP &&
                             gateDrive == DRIVE_FULL) begin
                    stateD = ST_ON;
                end
            end
            ST_SAG_OFF: begin
                if (!runOk) begin
                    stateD = ST_OFF;
                end else if (offDone) begin
                    stateD = ST_RAMP;
                end
            end
            ST_HOT_OFF: begin
                if (!runOk) begin
                    stateD = ST_OFF;
                end else if (flags.cooled) begin
                    stateD = ST_RAMP;
                end
            end
            default: begin
                stateD = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stateQ <= ST_OFF;
        end else begin
            stateQ <= stateD;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // soft-start ramp; zero step would stall, so it acts as one
    logic [8:0] driveSum;
    logic [7:0] stepEff;

    assign stepEff  = (stepQ == 8'h00) ? 8'h01 : stepQ;
    assign driveSum = {1'b0, gateDrive} + {1'b0, stepEff};

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gateDrive <= 8'h00;
        end else if (turnOn || !gateOn) begin
            gateDrive <= 8'h00;
        end else if (stateQ == ST_RAMP) begin
            gateDrive <= driveSum[8] ? DRIVE_FULL : driveSum[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fault flag, open drain
    logic assertOk;

    assign assertOk = SURGE_GRACE ? (faultCond && graceDone)
                                  : asrtDone;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            faultQ <= 1'b0;
        end else if (flags.lockout) begin
            faultQ <= 1'b0;
        end else if (!faultQ && assertOk) begin
            faultQ <= 1'b1;
        end else if (faultQ && relDone && !faultCond) begin
            // a fault returning on the last hold cycle keeps the flag
            faultQ <= 1'b0;
        end
    end

    // never drives high; the pull-up is outside
    assign faultO    = 1'b0;
    assign faultOe_n = !faultQ;

    ////////////////////////////////////////////////////////////////////////
    // apb slave, zero wait, read data captured in setup
    logic        mapped;
    logic [31:0] statusWord;

    assign pready = 1'b1;
    assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
                    (paddr == ADDR_FLAGS);

    always_comb begin
        statusWord = 32'h0000_0000;
        statusWord[ST_STATE_LSB +: 3] = stateQ;
        statusWord[ST_GATE_BIT]       = gateOn;
        statusWord[ST_FAULT_BIT]      = faultQ;
        statusWord[ST_GRACE_BIT]      = graceActive;
        statusWord[ST_LSEL_BIT]       = limitSel;
        statusWord[ST_DRIVE_LSB +: 8] = gateDrive;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= !mapped;
            if (paddr == ADDR_CTRL) begin
                prdata <= {24'h00_0000, stepQ};
            end else if (paddr == ADDR_STATUS) begin
                prdata <= statusWord;
            end else if (paddr == ADDR_FLAGS) begin
                prdata <= {25'h000_0000, flagsVec};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stepQ <= STEP_RST;
        end else if (psel && penable && pwrite && paddr == ADDR_CTRL) begin
            stepQ <= pwdata[STEP_LSB +: 8];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    AST_SAG_TRIP: assert property (
        gateOn && sagDone && runOk && !flags.overTemp
        |=> stateQ == ST_SAG_OFF && !gateOn)
        else $error("sag held full blank did not turn switch off");

    AST_SAG_ONLY_ON: assert property (
        !gateOn |=> !sagDone)
        else $error("sag timer ran with switch off");

    AST_SAG_RETRY: assert property (
        stateQ == ST_SAG_OFF && offDone && runOk |=> stateQ == ST_RAMP)
        else $error("switch not resumed after sag off time");

    AST_SAG_HOLD: assert property (
        stateQ == ST_SAG_OFF && !offDone && runOk
        |=> stateQ == ST_SAG_OFF)
        else $error("sag off interval cut short");

    AST_HOT_OFF: assert property (
        gateOn && flags.overTemp && runOk
        |=> stateQ == ST_HOT_OFF && !gateOn && faultCond)
        else $error("overtemperature did not shut switch off");

    AST_FAULT_SET: assert property (
        !faultQ && assertOk && !flags.lockout |=> faultQ && !faultOe_n)
        else $error("qualified fault did not pull flag low");

    AST_COOL_RESUME: assert property (
        stateQ == ST_HOT_OFF && flags.cooled && runOk |=> stateQ == ST_RAMP)
        else $error("switch not resumed after cool-down");

    AST_LOCKOUT: assert property (
        flags.lockout |=> !faultQ && !gateOn && faultOe_n)
        else $error("lockout left switch or fault active");

    AST_SOFTSTART: assert property (
        $rose(gateOn) |-> gateDrive == 8'h00 ##1 gateDrive <= stepEff)
        else $error("turn-on did not start ramp from zero");

    AST_FAULT_QUAL: assert property (
        $rose(faultQ) && !SURGE_GRACE |-> $past(asrtDone))
        else $error("fault flag set before qualification delay");

    AST_GRACE_SEL: assert property (
        gateOn |-> ((SURGE_GRACE && !graceDone)
                    ? (limitSel && faultCond == flags.limSurge)
                    : (!limitSel && faultCond == flags.limNorm)))
        else $error("wrong current limit selected for grace state");

    AST_FAULT_HOLD: assert property (
        $fell(faultQ) && !$past(flags.lockout)
        |-> $past(relDone) && !$past(faultCond))
        else $error("fault flag released before hold time");

endmodule : psfs_supervisor
`default_nettype wire

// >>> hw/psfs_sync.sv
// two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module psfs_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_q  <= '0;
            syncOut <= '0;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule : psfs_sync
`default_nettype wire

// >>> hw/psfs_timer.sv
// saturating interval counter with clear and terminal flag
`timescale 1ns/10ps
`default_nettype none
module psfs_timer #(
    parameter int W = 32
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic         run,
    input  wire logic         clr,
    input  wire logic [W-1:0] limit,
    output logic              done
);
    logic [W-1:0] cnt_q;

    assign done = (cnt_q >= limit);

    // clear wins; counter stops at the limit
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (clr) begin
            cnt_q <= '0;
        end else if (run && !done) begin
            cnt_q <= cnt_q + W'(1);
        end
    end
endmodule : psfs_timer
`default_nettype wire

// >>> verification/psfs_ctrl_model.sv
// system controller model: drives enable, reads the pulled-up fault line
`timescale 1ns/10ps
`default_nettype none
module psfs_ctrl_model #(
    parameter bit EN_ACTIVE_HIGH = 1'b1
) (
    input  wire logic runReq,
    input  wire logic faultO,
    input  wire logic faultOe_n,
    output logic      enablePin,
    output logic      faultLine
);
    ////////////////////////////////////////////////////////////////////////
    // level matches the build polarity of the enable pin
    assign enablePin = EN_ACTIVE_HIGH ? runReq : ~runReq;
    // external pull-up: a released line reads high, never the last value
    assign faultLine = faultOe_n ? 1'b1 : faultO;
endmodule : psfs_ctrl_model
`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench for the power switch supervisor
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import psfs_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst      = 1'b1;
    psfs_flags_t flags    = '0;
    logic        runReq   = 1'b0;
    logic        enablePin, faultLine, gateOn, limitSel, faultO, faultOe_n;
    logic [7:0]  gateDrive;
    logic [7:0]  paddr    = 8'h00;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [31:0] pwdata   = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err;
    psfs_flags_t pins;
    int          n_errors = 0;
    int          n_compared = 0;
    int          cycles = 0;
    int          n;

    always #50 core_clk = ~core_clk;
    assign pins = '{lockout: flags.lockout, sag: flags.sag,
        limNorm: flags.limNorm, limSurge: flags.limSurge,
        overTemp: flags.overTemp, cooled: flags.cooled, enable: enablePin};

    psfs_ctrl_model #(.EN_ACTIVE_HIGH(1'b1)) psfs_ctrl_model_i (
        .runReq(runReq), .faultO(faultO), .faultOe_n(faultOe_n),
        .enablePin(enablePin), .faultLine(faultLine));

    psfs_supervisor #(.EN_ACTIVE_HIGH(1'b1), .SURGE_GRACE(1'b0),
        .SHORT_CYC(20), .GRACE_CYC(80)) psfs_supervisor_i (
        .core_clk(core_clk), .rst(rst), .flagsPin(pins), .gateOn(gateOn),
        .gateDrive(gateDrive), .limitSel(limitSel), .faultO(faultO),
        .faultOe_n(faultOe_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // n counts cycles in [lo,hi]
    task automatic chk_n(input string what, input int lo, input int hi);
        chk(what, 32'h1, {31'h0, (n >= lo && n <= hi)});
    endtask : chk_n

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // only the bench ceiling ends a slave that never answers
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // sel 0 watches gateOn, 1 the fault line; n = cycles waited
    task automatic wait_for(input bit sel, input logic v, input int maxc);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while ((sel ? faultLine : gateOn) !== v && n < maxc);
    endtask : wait_for

    task automatic set_pin(input int idx, input logic v);
        @(posedge core_clk);
        flags[idx] <= v;
    endtask : set_pin

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl reset", 32'h10, rd);
        apb(1'b1, ADDR_CTRL, 32'h40);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl rw", 32'h40, rd);
        apb(1'b0, 8'h3C, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status off", 32'h0, rd);
        $display("test regs done");
    endtask : t_regs

    task automatic t_enable;
        @(posedge core_clk);
        runReq <= 1'b1;
        wait_for(0, 1'b1, 10);
        chk_n("turn-on delay", 2, 5);
        chk("drive from zero", 32'h0, gateDrive);
        @(negedge core_clk);
        chk("drive first step", 32'h40, gateDrive);
        wait_for(0, 1'b0, 12);
        chk("stays on", 32'h1, gateOn);
        chk("drive full", DRIVE_FULL, gateDrive);
        chk("fault idle", 32'h1, faultLine);
        $display("test enable done");
    endtask : t_enable

    task automatic t_sag;
        set_pin(5, 1'b1);
        repeat (10) @(posedge core_clk);
        flags.sag <= 1'b0;
        wait_for(0, 1'b0, 30);
        chk("short dip ignored", 32'h1, gateOn);
        set_pin(5, 1'b1);
        wait_for(0, 1'b0, 40);
        chk_n("sag trip", 20, 24);
        wait_for(0, 1'b1, 120);
        chk_n("sag retry", 79, 84);
        wait_for(0, 1'b0, 40);
        chk_n("sag repeat", 19, 24);
        set_pin(5, 1'b0);
        wait_for(0, 1'b1, 120);
        wait_for(0, 1'b0, 60);
        chk("sag recovered", 32'h1, gateOn);
        $display("test sag done");
    endtask : t_sag

    task automatic t_fault;
        set_pin(4, 1'b1);
        repeat (10) @(posedge core_clk);
        flags.limNorm <= 1'b0;
        wait_for(1, 1'b0, 40);
        chk("transient filtered", 32'h1, faultLine);
        set_pin(4, 1'b1);
        wait_for(1, 1'b0, 40);
        chk_n("fault assert", 20, 24);
        chk("normal limit", 32'h0, limitSel);
        set_pin(4, 1'b0);
        wait_for(1, 1'b1, 60);
        chk_n("fault release", 20, 26);
        $display("test fault done");
    endtask : t_fault

    task automatic t_thermal;
        set_pin(2, 1'b1);
        wait_for(0, 1'b0, 10);
        chk_n("hot off", 1, 5);
        wait_for(1, 1'b0, 40);
        chk("hot fault", 32'h0, faultLine);
        @(posedge core_clk);
        flags.overTemp <= 1'b0;
        flags.cooled <= 1'b1;
        wait_for(0, 1'b1, 10);
        chk_n("cool resume", 1, 6);
        set_pin(1, 1'b0);
        set_pin(2, 1'b1);
        wait_for(0, 1'b0, 10);
        chk_n("reheat off", 1, 6);
        @(posedge core_clk);
        flags.overTemp <= 1'b0;
        flags.cooled <= 1'b1;
        wait_for(0, 1'b1, 10);
        chk_n("second resume", 1, 6);
        set_pin(1, 1'b0);
        $display("test thermal done");
    endtask : t_thermal

    task automatic t_lockout;
        wait_for(1, 1'b1, 60);
        chk("hot fault release", 32'h1, faultLine);
        set_pin(6, 1'b1);
        wait_for(0, 1'b0, 10);
        chk_n("lockout off", 1, 5);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("lockout state", 32'h0, {29'h0, rd[2:0]});
        // enable goes first so lockout release cannot restart the switch
        @(posedge core_clk);
        runReq <= 1'b0;
        set_pin(6, 1'b0);
        wait_for(0, 1'b1, 10);
        chk("disabled", 32'h0, gateOn);
        $display("test lockout done");
    endtask : t_lockout

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    // ceiling well above the fewer than a thousand cycles the tests need
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_sim();
        end
    end

    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        t_enable();
        t_sag();
        t_fault();
        t_thermal();
        t_lockout();
        end_sim();
    end
endmodule : testbench
`default_nettype wire
